/* File: common/wake_mask_pkg.sv */
// constants, offsets and field layouts for the wakeup clock mask control
package wake_mask_pkg;
  // ==================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int MASK_NORMAL_US = 150;
  localparam int MASK_SHORT_US = 2;
  localparam int OVERSHOOT_US = 6;
  localparam int OUT_OF_SPEC_US = 4;
  localparam int MASK_NORMAL_CYC = MASK_NORMAL_US * CLK_MHZ;
  localparam logic [15:0] MASK_SHORT_CYC = 16'(MASK_SHORT_US * CLK_MHZ);
  localparam logic [15:0] OVERSHOOT_CYC = 16'(OVERSHOOT_US * CLK_MHZ);
  localparam logic [15:0] OUT_OF_SPEC_CYC = 16'(OUT_OF_SPEC_US * CLK_MHZ);
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // ==================================================
  // hazard thresholds in 100 kHz units, index is core level 0..3
  localparam logic [3:0][7:0] HAZARD_FREQ = {8'h7d, 8'h64, 8'h4b, 8'h32};

  // ==================================================
  // register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_SUPPLY = 4'h0;
  localparam logic [3:0] ADDR_CTL_FIVE = 4'h4;
  localparam logic [3:0] ADDR_OSC_FREQ = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  localparam int SUP_EN_BIT = 0;
  localparam int MON_EN_BIT = 1;
  localparam int SUP_FP_BIT = 2;
  localparam int MON_FP_BIT = 3;
  localparam int LEVEL_LSB = 4;
  localparam int DCO_SRC_BIT = 6;
  localparam logic [6:0] SUPPLY_RESET = 7'h43;
  localparam logic [2:0] DIVIDER_RESET = 3'h0;
  localparam logic [2:0] DIVIDER_MAX = 3'h5;
  localparam logic [7:0] OSC_FREQ_RESET = 8'h64;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==================================================
  // mask sequencing
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_MASK = 2'b01,
    PH_SPEC = 2'b10
  } phase_t;
endpackage

/* File: common/mask_if.sv */
// wakeup mask timer connection between controller and timer
`timescale 1ns/10ps
interface mask_if;
  logic start;
  logic short_mask;
  logic hazard;
  logic masked;
  logic overshoot;
  logic out_of_spec;
  modport timer(input start, input short_mask, input hazard,
    output masked, output overshoot, output out_of_spec);
  modport ctrl(output start, output short_mask, output hazard,
    input masked, input overshoot, input out_of_spec);
endinterface

/* File: logic/mask_timer.sv */
// wakeup mask, overshoot and out-of-spec timers
`timescale 1ns/10ps
module mask_timer #(
  parameter int NORMAL_CYCLES = wake_mask_pkg::MASK_NORMAL_CYC
) (
  input wire logic clk,
  input wire logic srst,
  mask_if.timer m
);
  import wake_mask_pkg::*;

  // ==================================================
  // state
  phase_t phase;
  logic [15:0] count;
  logic [15:0] over_cnt;
  logic short_q;
  logic hazard_q;
  logic [15:0] mask_len;
  logic [15:0] over_len;

  wire [15:0] mask_load = m.short_mask ? MASK_SHORT_CYC : 16'(NORMAL_CYCLES);
  wire mask_done = (phase == PH_MASK) && (count == CNT_ONE);
  wire spec_done = (phase == PH_SPEC) && (count == CNT_ONE);

  assign m.masked = (phase == PH_MASK); // [R9]
  assign m.overshoot = (over_cnt != CNT_ZERO); // [R1]
  assign m.out_of_spec = (phase == PH_SPEC); // [R5]

  // ==================================================
  // mask sequence; a new wakeup restarts the whole window
  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= PH_IDLE;
      count <= CNT_ZERO;
      short_q <= 1'b0;
      hazard_q <= 1'b0;
    end else if (m.start) begin
      phase <= PH_MASK; // [R9]
      count <= mask_load; // [R2] [R3]
      short_q <= m.short_mask;
      hazard_q <= m.hazard;
    end else begin
      case (phase)
        PH_MASK: begin
          count <= count - CNT_ONE;
          if (mask_done && short_q && hazard_q) begin
            phase <= PH_SPEC; // [R4] [R5]
            count <= OUT_OF_SPEC_CYC;
          end else if (mask_done) begin
            phase <= PH_IDLE;
          end
        end
        PH_SPEC: begin
          count <= count - CNT_ONE;
          if (spec_done) begin
            phase <= PH_IDLE;
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  // oscillator runs fast for a fixed window after every wakeup
  always_ff @(posedge clk) begin
    if (srst) begin
      over_cnt <= CNT_ZERO;
    end else if (m.start) begin
      over_cnt <= OVERSHOOT_CYC; // [R1]
    end else if (over_cnt != CNT_ZERO) begin
      over_cnt <= over_cnt - CNT_ONE;
    end
  end

  // ==================================================
  // checks; length counters exist only for them
  always_ff @(posedge clk) begin
    if (srst || m.start) begin
      mask_len <= CNT_ZERO;
      over_len <= CNT_ZERO;
    end else begin
      mask_len <= mask_len + (m.masked ? CNT_ONE : CNT_ZERO);
      over_len <= over_len + (m.overshoot ? CNT_ONE : CNT_ZERO);
    end
  end

  overshoot_start_a: assert property (@(posedge clk) disable iff (srst) // [R1]
    m.start |=> m.overshoot) else $error("overshoot not raised on wakeup");
  overshoot_len_a: assert property (@(posedge clk) disable iff (srst) // [R1]
    $fell(m.overshoot) && !$past(m.start) |-> over_len == OVERSHOOT_CYC)
    else $error("overshoot window length wrong");
  mask_normal_a: assert property (@(posedge clk) disable iff (srst) // [R2]
    $fell(m.masked) && !short_q |-> mask_len == 16'(NORMAL_CYCLES))
    else $error("normal mask length wrong");
  mask_short_a: assert property (@(posedge clk) disable iff (srst) // [R3]
    $fell(m.masked) && short_q && !$past(m.start) |-> mask_len == MASK_SHORT_CYC)
    else $error("short mask length wrong");
  spec_window_a: assert property (@(posedge clk) disable iff (srst) // [R5]
    $fell(m.masked) && !$past(m.start) && short_q && hazard_q |-> m.out_of_spec)
    else $error("out of spec window missing after short mask");
  hazard_only_a: assert property (@(posedge clk) disable iff (srst) // [R4]
    m.out_of_spec |-> hazard_q && short_q) else $error("out of spec without hazard");
endmodule

/* File: logic/wakeup_clock_mask_control.sv */
// wakeup clock mask control with axi4-lite registers
`timescale 1ns/10ps
// What this block does
// R1 - after leaving deep sleep level three or four the oscillator runs fast for up to 6 us.
// R2 - with supervisor and monitor in normal mode the cpu is masked for 150 us after wakeup.
// R3 - with both enables off or both full-performance selects on the mask lasts only 2 us.
// R4 - the short mask hurts only with the main clock from the oscillator above 5/7.5/10/12.5 MHz.
// R5 - under the short mask the cpu clock may run out of spec for about 4 us after the mask.
// R6 - software should set the main clock divider to 001 before entering deep sleep.
// R7 - after wakeup software waits 32/48/80/100 cycles per core level before clearing it.
// R8 - the secondary clock from the oscillator is never masked, so it shows the overshoot.
// R9 - the mask is a timer started at wakeup that gates the cpu clock, released glitch-free.
module wakeup_clock_mask_control #(
  parameter int MASK_NORMAL_CYCLES = wake_mask_pkg::MASK_NORMAL_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wake_event,
  output logic cpu_clock_enable,
  output logic main_clock_enable,
  output logic secondary_clock_fast,
  input wire logic [wake_mask_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wake_mask_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import wake_mask_pkg::*;

  // ==================================================
  // registers
  logic [6:0] supply_config;
  logic [2:0] main_clock_divider;
  logic [7:0] osc_freq;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_strb0_q;
  logic [4:0] div_cnt;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;

  mask_if mi();

  mask_timer #(.NORMAL_CYCLES(MASK_NORMAL_CYCLES)) u_timer (
    .clk(clk),
    .srst(srst),
    .m(mi.timer)
  );

  // ==================================================
  // mask selection
  wire supervisor_enable = supply_config[SUP_EN_BIT];
  wire monitor_enable = supply_config[MON_EN_BIT];
  wire supervisor_full_perf_select = supply_config[SUP_FP_BIT];
  wire monitor_full_perf_select = supply_config[MON_FP_BIT];
  wire [1:0] core_level = supply_config[LEVEL_LSB +: 2];
  wire main_from_dco = supply_config[DCO_SRC_BIT];
  assign mi.start = wake_event; // [R9]
  assign mi.short_mask = (!supervisor_enable && !monitor_enable) ||
    (supervisor_full_perf_select && monitor_full_perf_select); // [R3]
  assign mi.hazard = main_from_dco && (osc_freq > HAZARD_FREQ[core_level]); // [R4]

  // ==================================================
  // main clock divider: divide by 2**field, codes above 5 saturate
  wire [2:0] div_sel = (main_clock_divider > DIVIDER_MAX) ? DIVIDER_MAX : main_clock_divider;
  wire [4:0] div_reload = 5'((6'h01 << div_sel) - 6'h01);
  wire div_tick = (div_cnt == 5'h00);

  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt <= 5'h00;
      main_clock_enable <= 1'b0;
      cpu_clock_enable <= 1'b0;
      secondary_clock_fast <= 1'b0;
    end else begin
      div_cnt <= div_tick ? div_reload : div_cnt - 5'h01;
      main_clock_enable <= div_tick;
      // gating on the enable pulse, not the clock, keeps the release glitch-free
      cpu_clock_enable <= div_tick && !mi.masked; // [R9]
      secondary_clock_fast <= mi.overshoot; // [R8]
    end
  end

  // ==================================================
  // axi4-lite write: address and data taken in either order
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_hit = (aw_addr_q == ADDR_SUPPLY) || (aw_addr_q == ADDR_CTL_FIVE) ||
    (aw_addr_q == ADDR_OSC_FREQ);
  wire wr_en = do_write && w_strb0_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb0_q <= 1'b0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // fields live in byte 0, so only its strobe matters
  always_ff @(posedge clk) begin
    if (srst) begin
      supply_config <= SUPPLY_RESET;
      main_clock_divider <= DIVIDER_RESET;
      osc_freq <= OSC_FREQ_RESET;
    end else if (wr_en) begin
      if (aw_addr_q == ADDR_SUPPLY) begin
        supply_config <= w_data_q[6:0];
      end
      if (aw_addr_q == ADDR_CTL_FIVE) begin
        main_clock_divider <= w_data_q[2:0];
      end
      if (aw_addr_q == ADDR_OSC_FREQ) begin
        osc_freq <= w_data_q[7:0];
      end
    end
  end

  // ==================================================
  // axi4-lite read
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    if (s_axi_araddr == ADDR_SUPPLY) begin
      rd_data = {25'h000_0000, supply_config};
    end else if (s_axi_araddr == ADDR_CTL_FIVE) begin
      rd_data = {29'h0000_0000, main_clock_divider};
    end else if (s_axi_araddr == ADDR_OSC_FREQ) begin
      rd_data = {24'h00_0000, osc_freq};
    end else if (s_axi_araddr == ADDR_STATUS) begin
      rd_data = {28'h000_0000, mi.short_mask, mi.out_of_spec, mi.overshoot, mi.masked};
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==================================================
  // checks
  cpu_gate_a: assert property (@(posedge clk) disable iff (srst) // [R9]
    mi.masked |=> !cpu_clock_enable) else $error("cpu clock ran while masked");
  glitch_free_a: assert property (@(posedge clk) disable iff (srst) // [R9]
    cpu_clock_enable |-> main_clock_enable) else $error("cpu enable outside main tick");
  secondary_free_a: assert property (@(posedge clk) disable iff (srst) // [R8]
    wake_event |=> ##1 secondary_clock_fast) else $error("secondary overshoot not shown");
  // release waits for a main tick, never a partial pulse
  cpu_release_a: assert property (@(posedge clk) disable iff (srst) // [R9]
    !mi.masked && div_tick |=> cpu_clock_enable) else $error("cpu clock held after mask");
  secondary_idle_a: assert property (@(posedge clk) disable iff (srst) // [R8]
    !mi.overshoot |=> !secondary_clock_fast) else $error("secondary fast without overshoot");
  hazard_src_a: assert property (@(posedge clk) disable iff (srst) // [R4]
    mi.hazard |-> main_from_dco) else $error("hazard without oscillator source");
  div_reload_a: assert property (@(posedge clk) disable iff (srst) // [R6]
    div_tick |=> div_cnt == $past(div_reload)) else $error("divider reload wrong");
  main_idle_a: assert property (@(posedge clk) disable iff (srst) // [R6]
    !div_tick |=> !main_clock_enable) else $error("main tick outside divider wrap");
  divider_write_a: assert property (@(posedge clk) disable iff (srst) // [R6]
    wr_en && (aw_addr_q == ADDR_CTL_FIVE) |=> main_clock_divider == w_data_q[2:0])
    else $error("divider write lost");

  // ==================================================
  // bus checks; a response must stand until the master takes it
  bresp_hold_a: assert property (@(posedge clk) disable iff (srst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (@(posedge clk) disable iff (srst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  status_ro_a: assert property (@(posedge clk) disable iff (srst)
    do_write && (aw_addr_q == ADDR_STATUS) |=> s_axi_bresp == RESP_SLVERR)
    else $error("status write not refused");
endmodule

/* File: dv/firmware_model.sv */
// firmware side model: axi4-lite master plus low-power entry and exit steps
`timescale 1ns/10ps
module firmware_model (
  input wire logic clk,
  output logic [3:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [3:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // ==================================================
  // bus cycles
  int wait_cyc [4] = '{32, 48, 80, 100};
  // byte lanes offered with every write; the bench may narrow them
  logic [3:0] wr_strobe = 4'hf;
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= wr_strobe;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      // released lines flip so a stale value never looks valid
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        bready <= 1'b0;
        r = bresp;
        break;
      end
    end
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask
  // ==================================================
  // low-power steps
  task automatic enter_sleep();
    logic [1:0] r;
    axi_write(4'h4, 32'h0000_0001, r);
  endtask
  task automatic leave_sleep(input int level);
    logic [1:0] r;
    repeat (wait_cyc[level]) @(posedge clk);
    axi_write(4'h4, 32'h0000_0000, r);
  endtask
endmodule

/* File: dv/wakeup_clock_mask_control_tb.sv */
// self-checking bench for the wakeup clock mask control
`timescale 1ns/10ps
module wakeup_clock_mask_control_tb;
  import wake_mask_pkg::*;
  // ==================================================
  // signals
  localparam int NORM = 300;
  logic clk, srst, wake_event, cpu_clock_enable, main_clock_enable, secondary_clock_fast;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int mismatches = 0;
  int checks = 0;
  int fast_cnt = 0;
  int cfg_q [$];
  wakeup_clock_mask_control #(.MASK_NORMAL_CYCLES(NORM)) i_dut (.clk(clk), .srst(srst),
    .wake_event(wake_event), .cpu_clock_enable(cpu_clock_enable),
    .main_clock_enable(main_clock_enable), .secondary_clock_fast(secondary_clock_fast),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  firmware_model fw (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) if (secondary_clock_fast === 1'b1) fast_cnt++;
  // ==================================================
  // helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    fw.axi_write(a, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    fw.axi_read(a, d, r);
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // counts only zeros, so divider must be 0 here
  task automatic wake(output int n);
    fast_cnt = 0;
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    n = 0;
    repeat (2) @(negedge clk);
    while (cpu_clock_enable === 1'b0 && n < 20000) begin
      n++;
      @(negedge clk);
    end
  endtask
  // settle after a divider change, then count over a window
  task automatic pulses(input int c, output int p);
    p = 0;
    repeat (40) @(negedge clk);
    repeat (c) begin
      @(negedge clk);
      if (main_clock_enable === 1'b1) p++;
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    final_report();
  end
  // ==================================================
  // scenarios
  initial begin
    int n, sup, frq, lvl, sh, hz;
    logic [15:0] s;
    srst = 1'b1;
    wake_event = 1'b0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_SUPPLY, 32'h0000_0043, RESP_OKAY);
    rd(ADDR_CTL_FIVE, 32'h0000_0000, RESP_OKAY);
    rd(ADDR_OSC_FREQ, 32'h0000_0064, RESP_OKAY);
    rd(4'h2, 32'h0000_0000, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h0000_0000, RESP_SLVERR);
    // low byte lane off: write answered but ignored
    fw.wr_strobe = 4'he;
    wr(ADDR_OSC_FREQ, 32'h0000_0011, RESP_OKAY);
    fw.wr_strobe = 4'hf;
    rd(ADDR_OSC_FREQ, 32'h0000_0064, RESP_OKAY);
    // level boundaries: 0x4032 and 0x7c7d sit exactly on the threshold
    cfg_q = '{16'h4364, 16'h4064, 16'h4032, 16'h7c7d, 16'h7c7e};
    s = 16'hf2ce; // seed 62158
    repeat (2) begin
      s = lfsr_next(s);
      cfg_q.push_back(int'(s));
    end
    foreach (cfg_q[i]) begin
      sup = (cfg_q[i] >> 8) & 127;
      frq = cfg_q[i] & 255;
      wr(ADDR_SUPPLY, 32'(cfg_q[i] >> 8), RESP_OKAY);
      wr(ADDR_OSC_FREQ, 32'(frq), RESP_OKAY);
      rd(ADDR_SUPPLY, 32'(sup), RESP_OKAY);
      rd(ADDR_OSC_FREQ, 32'(frq), RESP_OKAY);
      lvl = (sup >> 4) & 3;
      sh = ((sup & 3) == 0) || ((sup & 12) == 12);
      hz = sh && ((sup >> 6) & 1) && (frq > 50 + 25 * lvl);
      wake(n);
      chk(32'(n), 32'(sh ? 2 * 100 : NORM));
      rd(ADDR_STATUS, 32'(sh * 8 + hz * 4 + 2), RESP_OKAY);
      repeat (700) @(posedge clk);
      chk(32'(fast_cnt), 32'(6 * 100));
      rd(ADDR_STATUS, 32'(sh * 8), RESP_OKAY);
    end
    wr(ADDR_SUPPLY, 32'h0000_0043, RESP_OKAY);
    fw.enter_sleep();
    pulses(16, n);
    chk(32'(n), 32'(8));
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    fw.leave_sleep(0);
    rd(ADDR_CTL_FIVE, 32'h0000_0000, RESP_OKAY);
    for (int d = 0; d < 8; d++) begin
      wr(ADDR_CTL_FIVE, 32'(d), RESP_OKAY);
      pulses(64, n);
      chk(32'(n), 32'(64 >> (d > 5 ? 5 : d)));
    end
    final_report();
  end
endmodule
